//--- hw/nws_consts.svh
// constants of the no-wait pipelined sram device logic
`ifndef NWS_CONSTS_SVH
`define NWS_CONSTS_SVH

`define NWS_ADDR_W        18
`define NWS_LANES         4
`define NWS_LANE_W        9
`define NWS_FIFO_DEPTH    16
`define NWS_BURST_START   2'h0
`define NWS_BURST_STEP    2'h1
`define NWS_OE_N_RST      1'b1
`define NWS_WR_READY_RST  1'b0

`endif

//--- hw/nws_fifo.sv
// parameterised valid/ready fifo holding queued writes
`timescale 1ns/1ps
`include "nws_consts.svh"

module nws_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `NWS_FIFO_DEPTH
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_srst,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic [WIDTH-1:0]      o_out_data
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
			$error("nws_fifo: DEPTH must be a power of two of at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             next_in_ready;
	logic             push;
	logic             pop;

	assign o_out_valid = (count != '0);
	assign o_out_data  = mem[rd_ptr];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count  = count;
		if (push) begin
			next_wr_ptr = wr_ptr + 1'b1;
		end
		if (pop) begin
			next_rd_ptr = rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
		// ready is a flop so the filling side sees no path from its own valid
		next_in_ready = (next_count != (AW+1)'(DEPTH));
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			wr_ptr     <= '0;
			rd_ptr     <= '0;
			count      <= '0;
			o_in_ready <= 1'b0;
		end else begin
			wr_ptr     <= next_wr_ptr;
			rd_ptr     <= next_rd_ptr;
			count      <= next_count;
			o_in_ready <= next_in_ready;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end

endmodule : nws_fifo

//--- hw/nws_pkg.sv
// types shared by the no-wait pipelined sram device logic
`include "nws_consts.svh"

package nws_pkg;

	// gray order along desel -> read -> write -> continued desel
	typedef enum logic [1:0] {
		NWS_DESEL      = 2'h0,
		NWS_READ       = 2'h1,
		NWS_WRITE      = 2'h3,
		NWS_DESEL_CONT = 2'h2
	} nws_state_type;

	typedef struct packed {
		logic                    valid;
		logic                    write;
		logic [`NWS_ADDR_W-1:0]  addr;
		logic [1:0]              seed;
		logic [1:0]              count;
		logic [`NWS_LANES-1:0]   lanes_n;
	} nws_cmd_type;

	typedef struct packed {
		logic [`NWS_ADDR_W-1:0]            addr;
		logic [`NWS_LANES*`NWS_LANE_W-1:0] data;
		logic [`NWS_LANES-1:0]             lanes_n;
	} nws_wr_type;

endpackage : nws_pkg

//--- hw/nws_sram.sv
// pipelined no-wait burst sram device: command pipeline, burst counter, array, lanes
`timescale 1ns/1ps
`include "nws_consts.svh"

// Function
// - step_load low loads a new address; high advances the burst, same type.
// - new cycle only with all three selects active, else deselect.
// - write only lanes whose strobe is low; all high aborts as no-op.
// - write_select_n at load picks write or read; continuation ignores it.
// - continued deselect only follows a deselect or continued deselect cycle.
// - lanes drive read data only with sleep and output_drive_n both low.
// - sleep_request high keeps data lanes high impedance whatever else.
// - deselect keeps lanes high impedance once any read already in flight has been driven.
// - burst_order high: next address is seed xor step count.
// - burst_order low selects linear burst order.
// - data drivers start high impedance from reset.
// - burst_order pin reads high when left open; strap it anyway.
module nws_sram
	import nws_pkg::*;
#(
	parameter int ADDR_W     = `NWS_ADDR_W,
	parameter int FIFO_DEPTH = `NWS_FIFO_DEPTH
) (
	input  wire logic                                i_sys_clk,
	input  wire logic                                i_srst,
	input  wire logic [`NWS_ADDR_W-3:0]              i_addr_hi,
	input  wire logic [1:0]                          i_burst_seed_bits,
	input  wire logic                                i_chip_select_n,
	input  wire logic                                i_chip_select_hi,
	input  wire logic                                i_chip_select_lo2_n,
	input  wire logic                                i_burst_step_load,
	input  wire logic                                i_write_select_n,
	input  wire logic [`NWS_LANES-1:0]               i_lane_write_n,
	input  wire logic                                i_clock_gate_n,
	input  wire logic                                i_output_drive_n,
	input  wire logic                                i_sleep_request,
	input  wire logic                                i_burst_order,
	input  wire logic [`NWS_LANES*`NWS_LANE_W-1:0]   i_data_lanes,
	output logic [`NWS_LANES*`NWS_LANE_W-1:0]        o_data_lanes,
	output logic                                     o_data_lanes_oe_n,
	output logic                                     o_write_ready,
	output logic                                     o_selected
);
	import nws_pkg::*;

	localparam int LW = `NWS_LANE_W;

	generate
		if (ADDR_W < 3 || ADDR_W > `NWS_ADDR_W) begin : g_bad_addr
			$error("nws_sram: ADDR_W out of range");
		end
	endgenerate

	// linear adds the step to the seed, interleaved xors it
	function automatic logic [1:0] burst_low(input logic [1:0] seed,
	                                         input logic [1:0] cnt,
	                                         input logic       linear);
		burst_low = linear ? (seed + cnt) : (seed ^ cnt);
	endfunction : burst_low

	nws_state_type state;
	nws_state_type next_state;
	nws_cmd_type   s1;
	nws_cmd_type   s2;
	nws_cmd_type   next_s1;
	nws_cmd_type   next_s2;
	logic          next_oe_n;
	logic          en;
	logic          sel_ok;
	logic          linear;
	logic [1:0]    step;
	nws_wr_type    push_entry;
	nws_wr_type    drain_entry;
	logic          push;
	logic          fifo_in_ready;
	logic          drain_valid;
	logic          drain_ready;

	assign en     = ~i_clock_gate_n;
	assign sel_ok = ~i_chip_select_n & i_chip_select_hi & ~i_chip_select_lo2_n;
	// an open pin is pulled high, so only a grounded strap picks linear
	assign linear = ~i_burst_order;
	assign step   = s1.count + `NWS_BURST_STEP;

	always_comb begin
		next_state = state;
		next_s1    = s1;
		next_s2    = s2;
		if (en) begin
			if (!i_burst_step_load) begin
				if (sel_ok) begin
					next_state      = i_write_select_n ? NWS_READ : NWS_WRITE;
					next_s1.valid   = 1'b1;
					next_s1.write   = ~i_write_select_n;
					next_s1.addr    = {i_addr_hi, i_burst_seed_bits};
					next_s1.seed    = i_burst_seed_bits;
					next_s1.count   = `NWS_BURST_START;
					next_s1.lanes_n = i_lane_write_n;
				end else begin
					next_state    = NWS_DESEL;
					next_s1.valid = 1'b0;
				end
			end else begin
				case (state)
					NWS_READ, NWS_WRITE: begin
						// type is kept from the load cycle, write_select_n ignored
						next_s1.count     = step;
						next_s1.addr[1:0] = burst_low(s1.seed, step, linear);
						next_s1.lanes_n   = i_lane_write_n;
					end
					default: begin
						next_state    = NWS_DESEL_CONT;
						next_s1.valid = 1'b0;
					end
				endcase
			end
			next_s2 = s1;
		end
		// drive only for a read in flight, never asleep or with drive off
		next_oe_n = ~(next_s2.valid & ~next_s2.write) | i_sleep_request
		            | i_output_drive_n;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			state             <= NWS_DESEL;
			s1                <= '0;
			s2                <= '0;
			o_data_lanes_oe_n <= `NWS_OE_N_RST;
			o_write_ready     <= `NWS_WR_READY_RST;
			o_selected        <= 1'b0;
		end else begin
			state             <= next_state;
			s1                <= next_s1;
			s2                <= next_s2;
			o_data_lanes_oe_n <= next_oe_n;
			o_write_ready     <= fifo_in_ready;
			o_selected        <= (next_state == NWS_READ) || (next_state == NWS_WRITE);
		end
	end

	// write data is taken two edges after the address edge, all-high strobes abort
	assign push = en & s2.valid & s2.write & ~(&s2.lanes_n) & fifo_in_ready;
	assign push_entry.addr    = s2.addr;
	assign push_entry.data    = i_data_lanes;
	assign push_entry.lanes_n = s2.lanes_n;
	// the array is left alone while frozen or asleep, so the queue can back up
	assign drain_ready = en & ~i_sleep_request;

	nws_fifo #(
		.WIDTH ($bits(nws_wr_type)),
		.DEPTH (FIFO_DEPTH)
	) u_wr_fifo (
		.i_sys_clk   (i_sys_clk),
		.i_srst      (i_srst),
		.i_in_valid  (push),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (push_entry),
		.o_out_valid (drain_valid),
		.i_out_ready (drain_ready),
		.o_out_data  (drain_entry)
	);

	// one array per lane so each strobe writes its own storage
	genvar g;
	generate
		for (g = 0; g < `NWS_LANES; g++) begin : g_lane
			logic [LW-1:0] lane_mem [2**ADDR_W];
			always_ff @(posedge i_sys_clk) begin
				if (drain_valid && drain_ready && !drain_entry.lanes_n[g]) begin
					lane_mem[drain_entry.addr[ADDR_W-1:0]] <= drain_entry.data[g*LW +: LW];
				end
			end
			// a read of a word still queued returns the older contents
			always_ff @(posedge i_sys_clk) begin
				if (en) begin
					o_data_lanes[g*LW +: LW] <= lane_mem[s1.addr[ADDR_W-1:0]];
				end
			end
		end
	endgenerate

	a_sleep_hiz: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		i_sleep_request |=> o_data_lanes_oe_n) else $error("lanes driven in sleep");

	a_drive_off_hiz: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		i_output_drive_n |=> o_data_lanes_oe_n) else $error("lanes driven with drive off");

	a_desel_hiz: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		(en && !i_burst_step_load && !sel_ok) ##1 en |=> o_data_lanes_oe_n)
		else $error("lanes driven after deselect");

	a_reset_hiz: assert property (@(posedge i_sys_clk)
		i_srst |=> o_data_lanes_oe_n && !o_selected) else $error("drivers on after reset");

	a_gate_hold: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		i_clock_gate_n |=> $stable(s1) && $stable(s2) && $stable(state))
		else $error("state moved while clock gated");

	a_new_load: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		(en && !i_burst_step_load && sel_ok) |=>
		s1.valid && s1.addr == $past({i_addr_hi, i_burst_seed_bits})
		&& s1.write == !$past(i_write_select_n)) else $error("new address not loaded");

	a_burst_inter: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		(en && i_burst_step_load && i_burst_order && s1.valid) |=>
		s1.addr[1:0] == ($past(s1.seed) ^ ($past(s1.count) + 2'h1)) && $stable(s1.write))
		else $error("interleaved burst address wrong");

	a_burst_linear: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		(en && i_burst_step_load && !i_burst_order && s1.valid) |=>
		s1.addr[1:0] == ($past(s1.addr[1:0]) + 2'h1)) else $error("linear burst address wrong");

	a_cont_desel: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		(state == NWS_DESEL_CONT) |->
		($past(state) == NWS_DESEL || $past(state) == NWS_DESEL_CONT))
		else $error("continued deselect without deselect");

	// watches the queue fill level, not the push term, so a leak through the queue shows
	a_write_abort: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		(en && s2.valid && s2.write && (&s2.lanes_n)) |=>
		u_wr_fifo.count <= $past(u_wr_fifo.count)) else $error("aborted write queued");

	a_read_timing: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		(en && s1.valid && !s1.write && !i_sleep_request && !i_output_drive_n)
		|=> !o_data_lanes_oe_n) else $error("read data not driven on time");

endmodule : nws_sram

//--- test/nws_master.sv
// bus master model: drives the sram pins and resolves the shared data lanes
`timescale 1ns/1ps

module nws_master (
	input  wire logic        i_sys_clk,
	input  wire logic [35:0] i_dev_data,
	input  wire logic        i_dev_oe_n,
	output logic [15:0]      o_addr_hi,
	output logic [1:0]       o_seed,
	output logic [2:0]       o_cs,
	output logic             o_step_load,
	output logic             o_write_select_n,
	output logic [3:0]       o_lane_write_n,
	output logic             o_clock_gate_n,
	output logic             o_output_drive_n,
	output logic             o_sleep,
	output logic             o_burst_order,
	output logic [35:0]      o_wire
);
	logic        wr_burst = 1'h0;
	logic        gate     = 1'h0;
	logic        rd_off   = 1'h0;
	logic        wv       = 1'h0;
	logic        s1_v     = 1'h0;
	logic        drv_v    = 1'h0;
	logic [35:0] wd       = 36'h0;
	logic [35:0] s1_d     = 36'h0;
	logic [35:0] drv_d    = 36'h0;
	logic [35:0] last     = 36'h0;

	initial begin
		o_addr_hi = 16'h0;
		o_seed = 2'h0;
		o_cs = 3'h4;
		o_step_load = 1'h0;
		o_write_select_n = 1'h1;
		o_lane_write_n = 4'hF;
		o_clock_gate_n = 1'h0;
		o_output_drive_n = 1'h1;
		o_sleep = 1'h0;
		o_burst_order = 1'h1; // open pin reads high
	end

	// write data goes on the wire one enabled edge after its address edge, held for the capture edge after that
	always @(posedge i_sys_clk) begin
		if (o_clock_gate_n == 1'h0) begin
			s1_v <= wv;
			s1_d <= wd;
			drv_v <= s1_v;
			drv_d <= s1_d;
		end
		last <= o_wire;
	end

	// released lanes show the inverse of the last value so stale data never matches
	always_comb o_wire = (i_dev_oe_n == 1'h0) ? i_dev_data : (drv_v ? drv_d : ~last);

	task automatic op(input logic [2:0] cs, input logic step_ld, input logic we_n,
		input logic [7:0] a, input logic [3:0] bw, input logic [35:0] d);
		@(posedge i_sys_clk);
		if (!step_ld && !gate) wr_burst = (cs == 3'h2) && !we_n;
		o_cs <= cs;
		o_step_load <= step_ld;
		o_write_select_n <= we_n;
		o_addr_hi <= {10'h0, a[7:2]};
		o_seed <= a[1:0];
		o_lane_write_n <= bw;
		o_clock_gate_n <= gate;
		o_output_drive_n <= wr_burst | rd_off; // outputs off before write data
		wv <= wr_burst;
		wd <= d;
		gate = 1'h0;
	endtask : op
endmodule : nws_master

//--- test/tb_pipelined_nowait_sram_bus.sv
// self-checking bench for the pipelined no-wait sram device
`timescale 1ns/1ps
`define CHK(got, want) \
	begin \
		tests_run++; \
		if ((got) !== (want)) begin \
			err_count++; \
			$display("[ERR] %0t got %h want %h", $time, (got), (want)); \
		end \
	end

module tb_pipelined_nowait_sram_bus;
	import nws_pkg::*;
	logic        clk = 1'h0;
	logic        srst = 1'h1;
	logic [15:0] addr_hi;
	logic [1:0]  seed;
	logic [2:0]  cs;
	logic [3:0]  bw;
	logic        step_ld, we_n, cke_n, drv_n, slp, mode, dev_oe_n, dev_wr_rdy, dev_sel;
	logic [35:0] din, dev_q;
	logic [35:0] mem [256];
	int          err_count = 0;
	int          tests_run = 0;

	always #5 clk = ~clk;

	nws_master u_master (
		.i_sys_clk        (clk),
		.i_dev_data       (dev_q),
		.i_dev_oe_n       (dev_oe_n),
		.o_addr_hi        (addr_hi),
		.o_seed           (seed),
		.o_cs             (cs),
		.o_step_load      (step_ld),
		.o_write_select_n (we_n),
		.o_lane_write_n   (bw),
		.o_clock_gate_n   (cke_n),
		.o_output_drive_n (drv_n),
		.o_sleep          (slp),
		.o_burst_order    (mode),
		.o_wire           (din)
	);

	nws_sram #(.ADDR_W(8), .FIFO_DEPTH(16)) u_dut (
		.i_sys_clk           (clk),
		.i_srst              (srst),
		.i_addr_hi           (addr_hi),
		.i_burst_seed_bits   (seed),
		.i_chip_select_n     (cs[2]),
		.i_chip_select_hi    (cs[1]),
		.i_chip_select_lo2_n (cs[0]),
		.i_burst_step_load   (step_ld),
		.i_write_select_n    (we_n),
		.i_lane_write_n      (bw),
		.i_clock_gate_n      (cke_n),
		.i_output_drive_n    (drv_n),
		.i_sleep_request     (slp),
		.i_burst_order       (mode),
		.i_data_lanes        (din),
		.o_data_lanes        (dev_q),
		.o_data_lanes_oe_n   (dev_oe_n),
		.o_write_ready       (dev_wr_rdy),
		.o_selected          (dev_sel)
	);

	function automatic logic [7:0] baddr(input logic [7:0] a, input int k);
		return mode ? {a[7:2], a[1:0] ^ k[1:0]} : {a[7:2], a[1:0] + k[1:0]};
	endfunction : baddr

	task automatic report_and_stop();
		if (err_count == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop

	task automatic idle(input int n);
		repeat (n) u_master.op(3'h4, 1'h0, 1'h1, 8'h0, 4'hF, 36'h0);
		#1;
	endtask : idle

	// continuation beats flip write select to show it is ignored there
	task automatic wr_burst(input logic [7:0] a, input logic [3:0] b, input logic [2:0] t);
		logic [7:0] x;
		for (int k = 0; k < 4; k++) begin
			x = baddr(a, k);
			for (int g = 0; g < 4; g++) if (!b[g]) mem[x][g*9 +: 9] = {t, x[5:0]};
			u_master.op(3'h2, k > 0, k > 0, a, b, {4{t, x[5:0]}});
		end
		idle(6);
	endtask : wr_burst

	task automatic rd_burst(input logic [7:0] a);
		for (int k = 0; k < 6; k++) begin
			u_master.op(k < 4 ? 3'h2 : 3'h4, k > 0 && k < 4, k == 0, a, 4'h0, 36'h0);
			#1;
			if (k >= 2) begin
				`CHK(dev_oe_n, 1'h0)
				`CHK(dev_q, mem[baddr(a, k - 2)])
			end
		end
	endtask : rd_burst

	task automatic sc_reset();
		int n;
		#1;
		`CHK(dev_oe_n, 1'h1)
		`CHK(dev_sel, 1'h0)
		n = 0;
		while (dev_wr_rdy !== 1'h1 && n < 8) begin
			@(posedge clk);
			#1;
			n++;
		end
		`CHK(dev_wr_rdy, 1'h1)
		if (dev_wr_rdy !== 1'h1) report_and_stop();
	endtask : sc_reset

	task automatic sc_bursts();
		for (int m = 1; m >= 0; m--) begin
			@(posedge clk);
			u_master.o_burst_order <= m[0];
			wr_burst(8'h11, 4'h0, 3'h1);
			rd_burst(8'h11);
			wr_burst(8'h13, 4'h5, 3'h2); // lanes 1 and 3 only
			wr_burst(8'h12, 4'hF, 3'h3); // all strobes high: aborted
			rd_burst(8'h13);
		end
	endtask : sc_bursts

	task automatic sc_select();
		logic [2:0] bad [3] = '{3'h6, 3'h0, 3'h3};
		foreach (bad[i]) begin
			u_master.op(bad[i], 1'h0, 1'h1, 8'h11, 4'hF, 36'h0);
			u_master.op(3'h2, 1'h1, 1'h1, 8'h11, 4'hF, 36'h0);
			u_master.op(3'h4, 1'h0, 1'h1, 8'h11, 4'hF, 36'h0);
			#1;
			`CHK(dev_oe_n, 1'h1)
			`CHK(dev_sel, 1'h0)
		end
	endtask : sc_select

	task automatic rd_quiet();
		for (int k = 0; k < 4; k++) begin
			u_master.op(k == 0 ? 3'h2 : 3'h4, 1'h0, 1'h1, 8'h11, 4'hF, 36'h0);
			#1;
			`CHK(dev_oe_n, 1'h1)
		end
	endtask : rd_quiet

	task automatic sc_async();
		u_master.rd_off = 1'h1;
		rd_quiet();
		u_master.rd_off = 1'h0;
		@(posedge clk);
		u_master.o_sleep <= 1'h1;
		rd_quiet();
		@(posedge clk);
		u_master.o_sleep <= 1'h0;
		idle(2);
	endtask : sc_async

	task automatic sc_gate();
		u_master.op(3'h2, 1'h0, 1'h1, 8'h12, 4'hF, 36'h0);
		u_master.gate = 1'h1;
		u_master.op(3'h2, 1'h0, 1'h0, 8'h20, 4'h0, 36'h0);
		u_master.op(3'h2, 1'h1, 1'h1, 8'h12, 4'hF, 36'h0);
		#1;
		// the ignored edge delays the read, so the lanes are still released here
		`CHK(dev_oe_n, 1'h1)
		u_master.op(3'h4, 1'h0, 1'h1, 8'h12, 4'hF, 36'h0);
		#1;
		`CHK(dev_q, mem[baddr(8'h12, 0)])
		`CHK(dev_oe_n, 1'h0)
		u_master.op(3'h4, 1'h0, 1'h1, 8'h12, 4'hF, 36'h0);
		#1;
		`CHK(dev_q, mem[baddr(8'h12, 1)])
		idle(2);
	endtask : sc_gate

	// sleep stalls the array so queued writes pile up until the queue refuses
	task automatic sc_fifo();
		int n;
		n = 0;
		@(posedge clk);
		u_master.o_sleep <= 1'h1;
		u_master.op(3'h2, 1'h0, 1'h0, 8'h40, 4'h0, 36'h5);
		#1;
		while (dev_wr_rdy === 1'h1 && n < 24) begin
			u_master.op(3'h2, 1'h1, 1'h0, 8'h40, 4'h0, 36'h5);
			#1;
			n++;
		end
		`CHK(n >= 14 && n < 24, 1'h1)
		if (n >= 24) report_and_stop();
		idle(1);
		@(posedge clk);
		u_master.o_sleep <= 1'h0;
		n = 0;
		while (dev_wr_rdy !== 1'h1 && n < 64) begin
			idle(1);
			n++;
		end
		`CHK(dev_wr_rdy, 1'h1)
		if (dev_wr_rdy !== 1'h1) report_and_stop();
	endtask : sc_fifo

	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'h0;
		sc_reset();
		sc_bursts();
		sc_select();
		sc_async();
		sc_gate();
		sc_fifo();
		report_and_stop();
	end
endmodule : tb_pipelined_nowait_sram_bus
